//--- design/itsl_defines.svh
// constants shared by both ends of the input edge time stamper link
`ifndef ITSL_DEFINES_SVH
`define ITSL_DEFINES_SVH
`define ITSL_MAX_INPUTS 128
`define ITSL_MSG_PER_REC 20
`define ITSL_NUM_REC 15
`define ITSL_REC_BASE 8'h64
`define ITSL_CFG_REC 8'hf0
`define ITSL_SLOT_FIRST 8'h04
`define ITSL_SPECIAL_SLOT 8'h02
`define ITSL_CH_PER_SLOT 16
`define ITSL_MSG_BYTES 12
`define ITSL_MSG_WORDS (`ITSL_MSG_BYTES / 4)
`define ITSL_MEM_DEPTH (`ITSL_NUM_REC * `ITSL_MSG_PER_REC)
`define ITSL_CODE_EDGE 8'h00
`define ITSL_CODE_STOP 8'h01
`define ITSL_CODE_FRAMELOSS 8'h02
`define ITSL_ST_IN 8'h01
`define ITSL_ST_OUT 8'h00
`define ITSL_SYNC_INTERVAL_S 8'h0a
`define ITSL_FILTER_MIN_US 8'h64
`define ITSL_STARTUP_S 10
`define ITSL_MCLK_HZ 10000000
`define ITSL_MS_CYCLES (`ITSL_MCLK_HZ / 1000)
`define ITSL_STARTUP_MS (`ITSL_STARTUP_S * 1000)
`define ITSL_HOST_HOLDOFF 3'h4
`endif

//--- design/itsl_pkg.sv
// types shared by both ends of the input edge time stamper link
package itsl_pkg;
	typedef struct packed {
		logic [7:0] slot;
		logic [7:0] chan;
		logic [7:0] status;
		logic [7:0] code;
		logic [63:0] stamp;
	} itsl_msg_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_HEAD = 2'b01,
		RD_BODY = 2'b11,
		RD_DONE = 2'b10
	} itsl_rd_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_REQ = 2'b01,
		H_RECV = 2'b11,
		H_WAIT = 2'b10
	} itsl_host_state_t;
endpackage

//--- design/itsl_if.sv
// link between stamping station and fieldbus master
`timescale 1ns/10ps
`default_nettype none
interface itsl_if;
	// configuration record
	logic cfgValid;
	logic [7:0] cfgRecord;
	logic [127:0] cfgMask;
	logic cfgRiseIncoming;
	logic [7:0] cfgFilterUs;
	logic cfgCardIrqOff;
	logic [7:0] cfgSyncIntervalS;
	logic cfgAck;
	logic cfgErr;
	// time frames
	logic timeValid;
	logic [63:0] timeValue;
	// interrupt and record read
	logic irq;
	logic [7:0] irqRecord;
	logic rdReq;
	logic [7:0] rdRecord;
	logic rdErr;
	logic rdValid;
	logic rdReady;
	logic [31:0] rdData;
	logic rdLast;
	modport station(input cfgValid, cfgRecord, cfgMask, cfgRiseIncoming,
		cfgFilterUs, cfgCardIrqOff, cfgSyncIntervalS, timeValid, timeValue,
		rdReq, rdRecord, rdReady,
		output cfgAck, cfgErr, irq, irqRecord, rdErr, rdValid, rdData, rdLast);
	modport master(output cfgValid, cfgRecord, cfgMask, cfgRiseIncoming,
		cfgFilterUs, cfgCardIrqOff, cfgSyncIntervalS, timeValid, timeValue,
		rdReq, rdRecord, rdReady,
		input cfgAck, cfgErr, irq, irqRecord, rdErr, rdValid, rdData, rdLast);
endinterface
`default_nettype wire

//--- design/itsl_station.sv
// station end: edge capture, record buffering, interrupt and record read
`timescale 1ns/10ps
`default_nettype none
`include "itsl_defines.svh"
//////////////////////////////////////////////////////////////////////////////
module itsl_station #(
	parameter int MS_CYCLES = `ITSL_MS_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// link
	itsl_if.station lnk,
	// input cards and station
	input wire logic [127:0] inputPins,
	input wire logic [127:0] stationLayout,
	input wire logic syncMode,
	input wire logic busCycleTick,
	output logic stampActive
);
	import itsl_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// configuration and time base
	logic [127:0] pinA_q, pinB_q, lvl_q, mask_q, edgePend_q, edgeLvl_q;
	logic active_q, riseIn_q, lost_q;
	logic stopPend_q, stopIn_q, lossPend_q, lossIn_q;
	logic [7:0] interval_q;
	logic [63:0] now_q;
	logic [31:0] tick_q, msSince_q;
	logic cfgAck_q, cfgErr_q;
	wire cfgOk = lnk.cfgRecord == `ITSL_CFG_REC &&
		(lnk.cfgMask & ~stationLayout) == 128'h0 &&
		lnk.cfgFilterUs == `ITSL_FILTER_MIN_US && lnk.cfgCardIrqOff;
	wire cfgOn = cfgOk && lnk.cfgMask != 128'h0;
	wire msTick = tick_q == 32'(MS_CYCLES - 1);
	// no frame for two intervals counts as a lost time frame
	wire [31:0] timeoutMs = 32'(interval_q) * 32'd2000;
	wire lossNow = !lost_q && msSince_q >= timeoutMs && active_q;
	wire gainNow = lost_q && lnk.timeValid;

	always_ff @(posedge mclk) begin
		pinA_q <= inputPins;
		pinB_q <= pinA_q;
		if (!resetn) begin
			now_q <= 64'h0;
			tick_q <= 32'h0;
			msSince_q <= 32'h0;
		end else if (lnk.timeValid) begin
			now_q <= lnk.timeValue;
			tick_q <= 32'h0;
			msSince_q <= 32'h0;
		end else if (msTick) begin
			now_q <= now_q + 64'h1;
			tick_q <= 32'h0;
			msSince_q <= msSince_q + 32'h1;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end

	// there is deliberately no precision field in the config record
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			active_q <= 1'b0;
			mask_q <= 128'h0;
			riseIn_q <= 1'b1;
			interval_q <= `ITSL_SYNC_INTERVAL_S;
			cfgAck_q <= 1'b0;
			cfgErr_q <= 1'b0;
		end else begin
			cfgAck_q <= lnk.cfgValid && cfgOk;
			cfgErr_q <= lnk.cfgValid && !cfgOk;
			if (lnk.cfgValid) begin
				active_q <= cfgOn;
				mask_q <= cfgOk ? lnk.cfgMask : 128'h0;
				riseIn_q <= lnk.cfgRiseIncoming;
				if (cfgOk) begin
					interval_q <= lnk.cfgSyncIntervalS;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// edge capture
	// in synchronous mode levels are compared only at the bus cycle
	wire sample = !syncMode || busCycleTick;
	wire [127:0] newEdge = (pinB_q ^ lvl_q) & mask_q &
		{128{active_q && sample}};
	logic [6:0] edgeIdx;
	logic anyEdge;
	always_comb begin
		edgeIdx = 7'h0;
		anyEdge = 1'b0;
		for (int i = 127; i >= 0; i--) begin
			if (edgePend_q[i]) begin
				edgeIdx = 7'(i);
				anyEdge = 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// message source; specials first, then lowest pending input
	itsl_rd_state_t rdState_q;
	logic [3:0] wrRec_q, rdRec_q, fullCnt_q;
	logic [4:0] wrIdx_q, msgIdx_q, rdLen_q;
	logic [1:0] wsel_q;
	logic [4:0] recCount [`ITSL_NUM_REC];
	itsl_msg_t mem [`ITSL_MEM_DEPTH];
	// appends pause during a read so a closing record cannot change
	wire canAppend = fullCnt_q < 4'(`ITSL_NUM_REC) &&
		rdState_q == RD_IDLE && !lnk.rdReq;
	wire takeStop = stopPend_q && canAppend;
	wire takeLoss = lossPend_q && canAppend && !stopPend_q;
	wire takeEdge = anyEdge && canAppend && !stopPend_q && !lossPend_q;
	wire take = takeStop || takeLoss || takeEdge;
	wire edgeInc = edgeLvl_q[edgeIdx] == riseIn_q;
	// index maps contiguously from slot 4 channel 0, sixteen per card
	wire [7:0] edgeSlot = `ITSL_SLOT_FIRST + {5'h0, edgeIdx[6:4]};
	itsl_msg_t msg;
	always_comb begin
		msg.stamp = now_q;
		if (takeStop || takeLoss) begin
			msg.slot = `ITSL_SPECIAL_SLOT;
			msg.chan = 8'h0;
			msg.code = takeStop ? `ITSL_CODE_STOP : `ITSL_CODE_FRAMELOSS;
			msg.status = (takeStop ? stopIn_q : lossIn_q) ?
				`ITSL_ST_IN : `ITSL_ST_OUT;
		end else begin
			msg.slot = edgeSlot;
			msg.chan = {4'h0, edgeIdx[3:0]};
			msg.code = `ITSL_CODE_EDGE;
			msg.status = edgeInc ? `ITSL_ST_IN : `ITSL_ST_OUT;
		end
	end
	wire [127:0] edgeTake = {127'h0, takeEdge} << edgeIdx;

	// a repeat change before the first is drained merges into one message
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lvl_q <= 128'h0;
			edgePend_q <= 128'h0;
			edgeLvl_q <= 128'h0;
			stopPend_q <= 1'b0;
			stopIn_q <= 1'b0;
			lossPend_q <= 1'b0;
			lossIn_q <= 1'b0;
			lost_q <= 1'b0;
		end else begin
			if (lnk.cfgValid) begin
				lvl_q <= pinB_q;
			end else if (sample) begin
				lvl_q <= pinB_q;
			end
			edgePend_q <= (edgePend_q & ~edgeTake) | newEdge;
			edgeLvl_q <= (edgeLvl_q & ~newEdge) | (pinB_q & newEdge);
			if (lnk.cfgValid && active_q != cfgOn) begin
				stopPend_q <= 1'b1;
				stopIn_q <= !cfgOn;
			end else if (takeStop) begin
				stopPend_q <= 1'b0;
			end
			if (lossNow || gainNow) begin
				lossPend_q <= 1'b1;
				lossIn_q <= lossNow;
				lost_q <= lossNow;
			end else if (takeLoss) begin
				lossPend_q <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// record ring and read engine
	wire [3:0] wrNext = wrRec_q == 4'(`ITSL_NUM_REC - 1) ? 4'h0 : wrRec_q + 4'h1;
	wire [3:0] rdNext = rdRec_q == 4'(`ITSL_NUM_REC - 1) ? 4'h0 : rdRec_q + 4'h1;
	wire recFill = take && wrIdx_q == 5'(`ITSL_MSG_PER_REC - 1);
	wire [8:0] wrAddr = 9'(wrRec_q * `ITSL_MSG_PER_REC) + 9'(wrIdx_q);
	wire [8:0] rdAddr = 9'(rdRec_q * `ITSL_MSG_PER_REC) + 9'(msgIdx_q);
	wire haveData = fullCnt_q != 4'h0 || wrIdx_q != 5'h0;
	wire [7:0] oldestNum = `ITSL_REC_BASE + {4'h0, rdRec_q};
	wire rdAccept = rdState_q == RD_IDLE && lnk.rdReq && haveData &&
		lnk.rdRecord == oldestNum;
	itsl_msg_t rdMsg;
	assign rdMsg = mem[rdAddr];
	// a message leaves as three words: header, then the stamp high and low
	wire [31:0] bodyWord = wsel_q == 2'h0 ? rdMsg[95:64] :
		(wsel_q == 2'h1 ? rdMsg[63:32] : rdMsg[31:0]);
	wire bodyLast = msgIdx_q == rdLen_q - 5'h1 &&
		wsel_q == 2'(`ITSL_MSG_WORDS - 1);
	logic pushReady;
	wire pushValid = rdState_q == RD_HEAD || rdState_q == RD_BODY;
	wire [32:0] pushData = rdState_q == RD_HEAD ?
		{1'b0, 27'h0, rdLen_q} : {bodyLast, bodyWord};
	wire push = pushValid && pushReady;

	always_ff @(posedge mclk) begin
		if (take) begin
			mem[wrAddr] <= msg;
			recCount[wrRec_q] <= wrIdx_q + 5'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdState_q <= RD_IDLE;
			wrRec_q <= 4'h0;
			rdRec_q <= 4'h0;
			wrIdx_q <= 5'h0;
			fullCnt_q <= 4'h0;
			msgIdx_q <= 5'h0;
			wsel_q <= 2'h0;
			rdLen_q <= 5'h0;
		end else begin
			if (recFill || (rdAccept && fullCnt_q == 4'h0)) begin
				wrRec_q <= wrNext;
				wrIdx_q <= 5'h0;
				fullCnt_q <= fullCnt_q + 4'h1;
			end else if (take) begin
				wrIdx_q <= wrIdx_q + 5'h1;
			end else if (rdState_q == RD_DONE) begin
				fullCnt_q <= fullCnt_q - 4'h1;
			end
			case (rdState_q)
				RD_IDLE: begin
					msgIdx_q <= 5'h0;
					wsel_q <= 2'h0;
					if (rdAccept) begin
						rdLen_q <= fullCnt_q == 4'h0 ? wrIdx_q : recCount[rdRec_q];
						rdState_q <= RD_HEAD;
					end
				end
				RD_HEAD: begin
					if (push) begin
						rdState_q <= RD_BODY;
					end
				end
				RD_BODY: begin
					if (push && bodyLast) begin
						rdState_q <= RD_DONE;
					end else if (push && wsel_q == 2'(`ITSL_MSG_WORDS - 1)) begin
						wsel_q <= 2'h0;
						msgIdx_q <= msgIdx_q + 5'h1;
					end else if (push) begin
						wsel_q <= wsel_q + 2'h1;
					end
				end
				RD_DONE: begin
					rdRec_q <= rdNext;
					rdState_q <= RD_IDLE;
				end
				default: begin
					rdState_q <= RD_IDLE;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// two-entry output buffer and link outputs
	logic outV_q, skV_q, outV_d, skV_d;
	logic [32:0] outD_q, skD_q, outD_d, skD_d;
	logic irq_q, rdErr_q, active2_q;
	logic [7:0] irqRec_q;
	assign pushReady = !skV_q;
	wire pop = outV_q && lnk.rdReady;
	always_comb begin
		outV_d = outV_q;
		outD_d = outD_q;
		skV_d = skV_q;
		skD_d = skD_q;
		if (pop || !outV_q) begin
			outV_d = skV_q || push;
			outD_d = skV_q ? skD_q : pushData;
			skV_d = 1'b0;
		end else if (push) begin
			skV_d = 1'b1;
			skD_d = pushData;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			outV_q <= 1'b0;
			skV_q <= 1'b0;
			outD_q <= 33'h0;
			skD_q <= 33'h0;
			irq_q <= 1'b0;
			irqRec_q <= `ITSL_REC_BASE;
			rdErr_q <= 1'b0;
			active2_q <= 1'b0;
		end else begin
			outV_q <= outV_d;
			outD_q <= outD_d;
			skV_q <= skV_d;
			skD_q <= skD_d;
			// any stored message, even in a partly filled record, keeps the level up while no read is in progress
			irq_q <= haveData && rdState_q == RD_IDLE;
			irqRec_q <= oldestNum;
			rdErr_q <= rdState_q == RD_IDLE && lnk.rdReq && !rdAccept;
			active2_q <= active_q;
		end
	end

	assign lnk.cfgAck = cfgAck_q;
	assign lnk.cfgErr = cfgErr_q;
	assign lnk.irq = irq_q;
	assign lnk.irqRecord = irqRec_q;
	assign lnk.rdErr = rdErr_q;
	assign lnk.rdValid = outV_q;
	assign lnk.rdData = outD_q[31:0];
	assign lnk.rdLast = outD_q[32];
	assign stampActive = active2_q;
endmodule // itsl_station
`default_nettype wire

//--- design/itsl_master.sv
// fieldbus master end: configuration, time frames, interrupt-driven reads
`timescale 1ns/10ps
`default_nettype none
`include "itsl_defines.svh"
module itsl_master #(
	parameter int MS_CYCLES = `ITSL_MS_CYCLES,
	parameter int STARTUP_MS = `ITSL_STARTUP_MS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// link
	itsl_if.master lnk,
	// user side
	input wire logic userCfgReq,
	input wire logic [127:0] userMask,
	input wire logic userRiseIncoming,
	input wire logic userTimeValid,
	input wire logic [63:0] userTime,
	output logic cfgDone,
	output logic cfgRejected,
	output logic userValid,
	input wire logic userReady,
	output logic [31:0] userWord,
	output logic userLast,
	output logic stampsTrusted
);
	import itsl_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// configuration and time forwarding
	logic cfgValid_q, riseIn_q, timeValid_q, done_q, rej_q;
	logic [127:0] mask_q;
	logic [63:0] time_q;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfgValid_q <= 1'b0;
			mask_q <= 128'h0;
			riseIn_q <= 1'b1;
			timeValid_q <= 1'b0;
			time_q <= 64'h0;
			done_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			cfgValid_q <= userCfgReq;
			if (userCfgReq) begin
				mask_q <= userMask;
				riseIn_q <= userRiseIncoming;
			end
			timeValid_q <= userTimeValid;
			time_q <= userTime;
			done_q <= lnk.cfgAck;
			rej_q <= lnk.cfgErr;
		end
	end
	assign lnk.cfgValid = cfgValid_q;
	assign lnk.cfgRecord = `ITSL_CFG_REC;
	assign lnk.cfgMask = mask_q;
	assign lnk.cfgRiseIncoming = riseIn_q;
	assign lnk.cfgFilterUs = `ITSL_FILTER_MIN_US;
	assign lnk.cfgCardIrqOff = 1'b1;
	assign lnk.cfgSyncIntervalS = `ITSL_SYNC_INTERVAL_S;
	assign lnk.timeValid = timeValid_q;
	assign lnk.timeValue = time_q;

	//////////////////////////////////////////////////////////////////////////
	// startup wait before stamps are trusted
	logic [31:0] tick_q, ms_q;
	logic trusted_q;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tick_q <= 32'h0;
			ms_q <= 32'h0;
			trusted_q <= 1'b0;
		end else begin
			tick_q <= tick_q == 32'(MS_CYCLES - 1) ? 32'h0 : tick_q + 32'h1;
			if (tick_q == 32'(MS_CYCLES - 1) && !trusted_q) begin
				ms_q <= ms_q + 32'h1;
			end
			trusted_q <= trusted_q || ms_q >= 32'(STARTUP_MS);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt-driven record read; one word held for the user at a time
	itsl_host_state_t st_q;
	logic rdReq_q, rdReady_q, uValid_q, uLast_q;
	logic [7:0] rdRec_q;
	logic [31:0] uWord_q;
	logic [2:0] hold_q;
	wire take = lnk.rdValid && rdReady_q;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_q <= H_IDLE;
			rdReq_q <= 1'b0;
			rdRec_q <= `ITSL_REC_BASE;
			rdReady_q <= 1'b0;
			uValid_q <= 1'b0;
			uLast_q <= 1'b0;
			uWord_q <= 32'h0;
			hold_q <= 3'h0;
		end else begin
			rdReq_q <= 1'b0;
			if (take) begin
				uWord_q <= lnk.rdData;
				uLast_q <= lnk.rdLast;
				uValid_q <= 1'b1;
				rdReady_q <= 1'b0;
			end else if (uValid_q && userReady) begin
				uValid_q <= 1'b0;
				rdReady_q <= st_q == H_RECV && !uLast_q;
			end
			case (st_q)
				H_IDLE: begin
					if (lnk.irq && !uValid_q) begin
						rdReq_q <= 1'b1;
						rdRec_q <= lnk.irqRecord;
						st_q <= H_REQ;
					end
				end
				H_REQ: begin
					rdReady_q <= 1'b1;
					st_q <= H_RECV;
				end
				H_RECV: begin
					if ((take && lnk.rdLast) || lnk.rdErr) begin
						hold_q <= `ITSL_HOST_HOLDOFF;
						st_q <= H_WAIT;
					end
				end
				H_WAIT: begin
					// the interrupt level lags the read by a few cycles
					rdReady_q <= 1'b0;
					hold_q <= hold_q - 3'h1;
					if (hold_q == 3'h1) begin
						st_q <= H_IDLE;
					end
				end
				default: begin
					st_q <= H_IDLE;
				end
			endcase
		end
	end
	assign lnk.rdReq = rdReq_q;
	assign lnk.rdRecord = rdRec_q;
	assign lnk.rdReady = rdReady_q;
	assign cfgDone = done_q;
	assign cfgRejected = rej_q;
	assign userValid = uValid_q;
	assign userWord = uWord_q;
	assign userLast = uLast_q;
	assign stampsTrusted = trusted_q;
endmodule // itsl_master
`default_nettype wire

//--- bench/itsl_assertions.sv
// concurrent checks on the link between station and fieldbus master
`timescale 1ns/10ps
`default_nettype none
module itsl_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// configuration answer
	input wire logic cfgValid,
	input wire logic cfgAck,
	input wire logic cfgErr,
	// record read
	input wire logic [7:0] irqRecord,
	input wire logic rdReq,
	input wire logic rdErr,
	input wire logic rdValid,
	input wire logic rdReady,
	input wire logic [31:0] rdData,
	input wire logic rdLast
);
	import itsl_pkg::*;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] hdr_q;
	wire logic take;
	wire logic msgWord;
	assign take = rdValid && rdReady;
	assign cnt_d = rdLast ? 8'h00 : cnt_q + 8'h01;
	// first word of each three-word message
	assign msgWord = cnt_q != 8'h00 && (cnt_q - 8'h01) % 8'h03 == 8'h00;
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= 8'h00;
			hdr_q <= 8'h00;
		end else if (take) begin
			cnt_q <= cnt_d;
			hdr_q <= (cnt_q == 8'h00) ? rdData[7:0] : hdr_q;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	//////////////////////////////////////////////////////////////////////
	a_cfg_one_answer: assert property (cfgValid |=> cfgAck != cfgErr)
		else $error("config request not answered by exactly one pulse");
	a_cfg_answer_cause: assert property ((cfgAck || cfgErr) |-> $past(cfgValid))
		else $error("config answer without a request");
	a_irq_rec_range: assert property (irqRecord inside {[8'h64:8'h72]})
		else $error("interrupt names a record outside the ring");
	a_read_answered: assert property (rdReq |-> ##[1:2] (rdErr || rdValid))
		else $error("read request left unanswered");
	a_word_held: assert property (rdValid && !rdReady |=>
		rdValid && $stable(rdData) && $stable(rdLast))
		else $error("read word changed while stalled");
	a_header_count: assert property (rdValid && cnt_q == 8'h00 |->
		rdData inside {[32'h1:32'h14]} && !rdLast)
		else $error("record header count out of range");
	a_record_length: assert property (take && rdLast |->
		cnt_q == 8'h03 * hdr_q)
		else $error("record length does not match its header");
	a_msg_fields: assert property (rdValid && msgWord |->
		(rdData[31:16] == 16'h0200 && rdData[15:8] inside {8'h00, 8'h01} &&
		rdData[7:0] inside {8'h01, 8'h02}) ||
		(rdData[31:24] inside {[8'h04:8'h0b]} && rdData[23:16] < 8'h10 &&
		rdData[7:0] == 8'h00))
		else $error("message slot, channel or code malformed");
endmodule // itsl_assertions
`default_nettype wire

//--- bench/tb_input_edge_time_stamper.sv
// testbench: both link ends joined, user sides driven and judged
`timescale 1ns/10ps
`default_nettype none
module tb_input_edge_time_stamper;
	import itsl_pkg::*;
	localparam int MSC = 4;
	logic mclk, resetn, userCfgReq, userRiseIncoming, userTimeValid;
	logic userReady, syncMode, busCycleTick, cfgDone, cfgRejected;
	logic userValid, userLast, stampsTrusted, stampActive;
	logic [127:0] userMask, inputPins, stationLayout;
	logic [63:0] userTime;
	logic [31:0] userWord;
	int fails, n_compared;
	itsl_if lnk();
	itsl_station #(.MS_CYCLES(MSC)) u_itsl_station(.mclk(mclk),
		.resetn(resetn), .lnk(lnk.station), .inputPins(inputPins),
		.stationLayout(stationLayout), .syncMode(syncMode),
		.busCycleTick(busCycleTick), .stampActive(stampActive));
	itsl_master #(.MS_CYCLES(MSC), .STARTUP_MS(5)) u_itsl_master(.mclk(mclk),
		.resetn(resetn), .lnk(lnk.master), .userCfgReq(userCfgReq),
		.userMask(userMask), .userRiseIncoming(userRiseIncoming),
		.userTimeValid(userTimeValid), .userTime(userTime),
		.cfgDone(cfgDone), .cfgRejected(cfgRejected), .userValid(userValid),
		.userReady(userReady), .userWord(userWord), .userLast(userLast),
		.stampsTrusted(stampsTrusted));
	itsl_assertions u_itsl_assertions(.mclk(mclk), .resetn(resetn),
		.cfgValid(lnk.cfgValid), .cfgAck(lnk.cfgAck), .cfgErr(lnk.cfgErr),
		.irqRecord(lnk.irqRecord), .rdReq(lnk.rdReq), .rdErr(lnk.rdErr),
		.rdValid(lnk.rdValid), .rdReady(lnk.rdReady), .rdData(lnk.rdData),
		.rdLast(lnk.rdLast));
	//////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// inputs always move 2 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic frame(input logic [63:0] t);
		userTime = t;
		userTimeValid = 1'h1;
		tick(1);
		userTimeValid = 1'h0;
	endtask
	task automatic cfg(input logic [127:0] m, input logic r, input logic ok);
		int n;
		userMask = m;
		userRiseIncoming = r;
		userCfgReq = 1'h1;
		tick(1);
		userCfgReq = 1'h0;
		n = 0;
		while (cfgDone !== 1'h1 && cfgRejected !== 1'h1 && n < 20) begin
			tick(1);
			n++;
		end
		chk("config accepted", ok, cfgDone);
		chk("config refused", !ok, cfgRejected);
		tick(2);
		chk("stamping active", ok && m != 0, stampActive);
	endtask
	// one record of one message; t0 all ones skips the stamp check
	task automatic rec(input logic [31:0] exp, input logic [63:0] t0);
		logic [31:0] w [$];
		int n;
		logic done;
		done = 1'h0;
		n = 0;
		// a word counts when valid and ready stand before the taking edge
		while (!done && n < 300) begin
			if (userValid === 1'h1 && userReady === 1'h1) begin
				w.push_back(userWord);
				done = userLast === 1'h1;
			end
			tick(1);
			n++;
		end
		chk("record words", 4, w.size());
		if (w.size() == 4) begin
			chk("record count", 1, w[0]);
			chk("message head", exp, w[1]);
			if (t0 != '1)
				chk("stamp near frame", 1, {w[2], w[3]} - t0 <= 3);
		end
	endtask
	task automatic edge_at(input int i, input logic v, input logic [63:0] t);
		frame(t);
		inputPins[i] = v;
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("active after reset", 0, stampActive);
		chk("first record", 8'h64, lnk.irqRecord);
		chk("trusted early", 0, stampsTrusted);
		tick(5 * MSC + 6);
		chk("trusted later", 1, stampsTrusted);
	endtask
	task automatic t_on;
		cfg(128'h20001, 1'h1, 1'h1);
		rec(32'h02000001, '1);
	endtask
	task automatic t_rise;
		inputPins[5] = 1'h1;
		tick(12);
		chk("unmonitored pin quiet", 0, lnk.irq);
		edge_at(0, 1'h1, 64'h1000);
		rec(32'h04000100, 64'h1000);
	endtask
	// far side stalls; the header word must wait intact
	task automatic t_stall;
		userReady = 1'h0;
		edge_at(17, 1'h1, 64'h2000);
		tick(40);
		chk("word held", 1, userValid);
		chk("held header", 1, userWord);
		userReady = 1'h1;
		rec(32'h05010100, 64'h2000);
	endtask
	task automatic t_fall_in;
		cfg(128'h20001, 1'h0, 1'h1);
		edge_at(17, 1'h0, 64'h3000);
		rec(32'h05010100, 64'h3000);
		edge_at(0, 1'h0, 64'h4000);
		rec(32'h04000100, 64'h4000);
		edge_at(0, 1'h1, 64'h5000);
		rec(32'h04000000, 64'h5000);
	endtask
	// synchronous mode: levels are looked at only on the bus cycle
	task automatic t_sync;
		syncMode = 1'h1;
		edge_at(0, 1'h0, 64'h6000);
		tick(12);
		chk("no stamp between bus cycles", 0, lnk.irq);
		busCycleTick = 1'h1;
		tick(1);
		busCycleTick = 1'h0;
		rec(32'h04000100, '1);
		syncMode = 1'h0;
	endtask
	task automatic t_bad;
		cfg(128'h10000000001, 1'h1, 1'h0);
		rec(32'h02000101, '1);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		n_compared = 0;
		resetn = 1'h0;
		userCfgReq = 1'h0;
		userMask = '0;
		userRiseIncoming = 1'h1;
		userTimeValid = 1'h0;
		userTime = '0;
		userReady = 1'h1;
		inputPins = '0;
		stationLayout = 128'hffffffff;
		syncMode = 1'h0;
		busCycleTick = 1'h0;
		tick(2);
		resetn = 1'h1;
		t_reset;
		t_on;
		t_rise;
		t_stall;
		t_fall_in;
		t_sync;
		t_bad;
		close_out;
	end
	// a hang is cut short well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		close_out;
	end
endmodule // tb_input_edge_time_stamper
`default_nettype wire
